// ===== rtl/itw_pkg.sv
// package for the interval timer / watchdog block
// assumes a byte-wide register port and one core clock
package itw_pkg;
	localparam int CLK_HZ = 20000000;
	localparam int CLK_PERIOD_NS = 50;
	localparam logic [7:0] ADDR_BASIC_COUNT = 8'hf1;
	localparam logic [7:0] ADDR_CLOCK_CONTROL = 8'hf2;
	localparam logic [7:0] ADDR_WDOG_COMPARE = 8'hf4;
	localparam logic [7:0] ADDR_WDOG_DISABLE = 8'hf6;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf8;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hf9;
	localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h17;
	localparam logic [7:0] WDOG_COMPARE_RESET = 8'h7f;
	localparam logic [7:0] WDOG_DISABLE_RESET = 8'h00;
	localparam logic [7:0] WDOG_DISABLE_CODE = 8'ha5;
	localparam int CC_FUNC_SEL_BIT = 4;
	localparam int CC_CLEAR_BIT = 3;
	localparam int WC_CLEAR_BIT = 7;
	localparam int IRQ_BASIC_BIT = 0;
	localparam int IRQ_WDOG_BIT = 1;
	localparam int PRESCALE_W = 10;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;
endpackage

// ===== rtl/interval_timer_watchdog.sv
// basic interval timer with 7-bit watchdog / periodic timer
// assumes bus inputs synchronous to i_core_clk; fxin is the core clock
//
// Local design decision: the strobed register port.
`timescale 1ns/1ps
module interval_timer_watchdog
	import itw_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_reset,
	// register port
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	// events
	output logic o_irq,
	output logic o_basic_overflow_irq,
	output logic o_watchdog_irq,
	output logic o_cpu_reset
);
	reg_req_t req;
	logic [PRESCALE_W-1:0] pre_r;
	logic [7:0] basic_counter_value_r;
	logic [6:0] wdog_cnt_r;
	logic [2:0] basic_source_select_r;
	logic watchdog_function_select_r;
	logic basic_counter_clear_r;
	logic watchdog_counter_clear_r;
	logic [6:0] watchdog_compare_value_r;
	logic [7:0] watchdog_disable_code_reg_r;
	logic [1:0] irq_status_r;
	logic [1:0] irq_mask_r;
	logic tick;
	logic ovf;
	logic match;
	logic [1:0] irq_set;
	logic [7:0] rdata_nxt;

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// divider tap for the selected source; pulses once every 2^(sel+3) clocks
	function automatic logic tap_pulse(input logic [PRESCALE_W-1:0] p,
		input logic [2:0] sel);
		logic [PRESCALE_W-1:0] m;
		m = PRESCALE_W'((32'h8 << sel) - 32'h1);
		tap_pulse = ((p & m) == m);
	endfunction

	// prescaler free-runs; the counter only steps on selected tap
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			pre_r <= '0;
		end else begin
			pre_r <= pre_r + 1'b1;
		end
	end

	assign tick = tap_pulse(pre_r, basic_source_select_r);
	assign ovf = tick && (basic_counter_value_r == 8'hff);
	assign match = (wdog_cnt_r == watchdog_compare_value_r);

	// basic counter; its value after reset is not promised to software
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			basic_counter_value_r <= 8'h00;
		end else if (basic_counter_clear_r) begin
			basic_counter_value_r <= 8'h00;
		end else if (tick) begin
			basic_counter_value_r <= basic_counter_value_r + 8'h01;
		end
	end

	// watchdog counter steps on basic overflow only
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			wdog_cnt_r <= 7'h00;
		end else if (watchdog_counter_clear_r) begin
			wdog_cnt_r <= 7'h00;
		end else if (ovf) begin
			if (match && !watchdog_function_select_r) begin
				wdog_cnt_r <= 7'h00;
			end else begin
				wdog_cnt_r <= wdog_cnt_r + 7'h01;
			end
		end
	end

	// match is only taken on a step so one event per interval
	assign irq_set[IRQ_BASIC_BIT] = ovf;
	assign irq_set[IRQ_WDOG_BIT] = ovf && match;

	// control registers
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			basic_source_select_r <= CLOCK_CONTROL_RESET[2:0];
			basic_counter_clear_r <= CLOCK_CONTROL_RESET[CC_CLEAR_BIT];
			watchdog_function_select_r <= CLOCK_CONTROL_RESET[CC_FUNC_SEL_BIT];
			watchdog_counter_clear_r <= WDOG_COMPARE_RESET[WC_CLEAR_BIT];
			watchdog_compare_value_r <= WDOG_COMPARE_RESET[6:0];
			watchdog_disable_code_reg_r <= WDOG_DISABLE_RESET;
			irq_mask_r <= 2'h0;
		end else begin
			basic_counter_clear_r <= 1'b0;
			watchdog_counter_clear_r <= 1'b0;
			if (req.wr) begin
				case (req.addr)
					ADDR_CLOCK_CONTROL: begin
						basic_source_select_r <= req.wdata[2:0];
						basic_counter_clear_r <= req.wdata[CC_CLEAR_BIT];
						watchdog_function_select_r <= req.wdata[CC_FUNC_SEL_BIT];
					end
					ADDR_WDOG_COMPARE: begin
						watchdog_compare_value_r <= req.wdata[6:0];
						watchdog_counter_clear_r <= req.wdata[WC_CLEAR_BIT];
					end
					ADDR_WDOG_DISABLE: begin
						watchdog_disable_code_reg_r <= req.wdata;
					end
					ADDR_IRQ_MASK: begin
						irq_mask_r <= req.wdata[1:0];
					end
					default: begin
					end
				endcase
			end
		end
	end

	// sticky status; a new event beats the read-clear
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			irq_status_r <= 2'h0;
		end else if (req.rd && req.addr == ADDR_IRQ_STATUS) begin
			irq_status_r <= irq_set;
		end else begin
			irq_status_r <= irq_status_r | irq_set;
		end
	end

	// read mux; the count register ignores writes
	always_comb begin
		rdata_nxt = 8'h00;
		case (req.addr)
			ADDR_BASIC_COUNT: rdata_nxt = basic_counter_value_r;
			ADDR_CLOCK_CONTROL: rdata_nxt = {3'h0, watchdog_function_select_r,
				basic_counter_clear_r, basic_source_select_r};
			ADDR_WDOG_COMPARE: rdata_nxt = {watchdog_counter_clear_r,
				watchdog_compare_value_r};
			ADDR_WDOG_DISABLE: rdata_nxt = watchdog_disable_code_reg_r;
			ADDR_IRQ_STATUS: rdata_nxt = {6'h00, irq_status_r};
			ADDR_IRQ_MASK: rdata_nxt = {6'h00, irq_mask_r};
			default: rdata_nxt = 8'h00;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= req.rd ? rdata_nxt : 8'h00;
		end
	end

	// outputs, all registered
	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			o_irq <= 1'b0;
			o_basic_overflow_irq <= 1'b0;
			o_watchdog_irq <= 1'b0;
			o_cpu_reset <= 1'b0;
		end else begin
			o_irq <= |((irq_status_r | irq_set) & irq_mask_r);
			o_basic_overflow_irq <= irq_set[IRQ_BASIC_BIT];
			// a match always pulses the interrupt, in either role
			o_watchdog_irq <= irq_set[IRQ_WDOG_BIT];
			// exact byte compare, so near-miss codes leave reset armed
			o_cpu_reset <= irq_set[IRQ_WDOG_BIT] && watchdog_function_select_r
				&& (watchdog_disable_code_reg_r != WDOG_DISABLE_CODE);
		end
	end
endmodule

// ===== sim/itw_assertions.sv
// port checker for the interval timer / watchdog
// assumes one clock and a synchronous reset
`timescale 1ns/1ps
module itw_chk (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] o_rdata,
	input wire logic o_irq,
	input wire logic o_basic_overflow_irq,
	input wire logic o_watchdog_irq,
	input wire logic o_cpu_reset
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_reset);
	sequence s_clr; i_wr && i_addr == 8'hf2 && i_wdata[3]; endsequence
	sequence s_rdc; i_rd && i_addr == 8'hf1; endsequence
	// the clear lands one cycle after the write, so the read must come after that
	property p_clr; s_clr ##2 s_rdc |=> o_rdata == 8'h00; endproperty
	a_clr: assert property (p_clr) else $error("count kept after clear");
	property p_idle; !i_rd |=> o_rdata == 8'h00; endproperty
	a_idle: assert property (p_idle) else $error("read data without read");
	sequence s_wc; i_wr && i_addr == 8'hf4 && !i_wdata[7]; endsequence
	property p_cmp; s_wc ##1 i_rd && i_addr == 8'hf4 |=> o_rdata == $past(i_wdata, 2); endproperty
	a_cmp: assert property (p_cmp) else $error("compare readback wrong");
	property p_bo; o_basic_overflow_irq |=> !o_basic_overflow_irq [*8]; endproperty
	a_bo: assert property (p_bo) else $error("overflow too soon");
	property p_wd; o_watchdog_irq |=> !o_watchdog_irq; endproperty
	a_wd: assert property (p_wd) else $error("match pulse too long");
	property p_rs; o_cpu_reset |-> o_watchdog_irq; endproperty
	a_rs: assert property (p_rs) else $error("reset without match");
	property p_rs1; o_cpu_reset |=> !o_cpu_reset; endproperty
	a_rs1: assert property (p_rs1) else $error("reset pulse too long");
	// the watchdog only steps on an overflow, so a match sits close to one
	property p_step;
		o_watchdog_irq |-> o_basic_overflow_irq || $past(o_basic_overflow_irq)
			|| $past(o_basic_overflow_irq, 2);
	endproperty
	a_step: assert property (p_step) else $error("match off overflow");
endmodule
bind interval_timer_watchdog itw_chk chk_u (.i_core_clk(i_core_clk), .i_reset(i_reset),
	.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_irq(o_irq), .o_basic_overflow_irq(o_basic_overflow_irq),
	.o_watchdog_irq(o_watchdog_irq), .o_cpu_reset(o_cpu_reset));

// ===== sim/interval_timer_watchdog_bench.sv
// bench for the interval timer / watchdog
// assumes a bus that never stalls and read data one cycle late
`timescale 1ns/1ps
module interval_timer_watchdog_bench;
	logic i_core_clk = 0, i_reset = 1, i_wr = 0, i_rd = 0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
	logic o_irq, o_basic_overflow_irq, o_watchdog_irq, o_cpu_reset;
	int error_cnt = 0, samples_checked = 0;
	interval_timer_watchdog dut_u (.i_core_clk(i_core_clk), .i_reset(i_reset),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_irq(o_irq), .o_basic_overflow_irq(o_basic_overflow_irq),
		.o_watchdog_irq(o_watchdog_irq), .o_cpu_reset(o_cpu_reset));
	initial begin
		forever #25 i_core_clk = ~i_core_clk;
	end
	task automatic cmp(logic [7:0] g, logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic bus(logic w, logic r, logic [7:0] a, logic [7:0] d);
		i_wr <= w;
		i_rd <= r;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_core_clk);
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		bus(0, 1, a, 8'h00);
		#1 cmp(o_rdata, e);
		bus(0, 0, 8'h00, 8'h00);
	endtask
	// bounded wait, so a silent design cannot hang the run
	task automatic ev(logic wd, output int n, output logic rs);
		bus(0, 0, 8'h00, 8'h00);
		for (n = 0; n < 20000; n++) begin
			@(negedge i_core_clk);
			if ((wd ? o_watchdog_irq : o_basic_overflow_irq) === 1'b1) break;
		end
		rs = o_cpu_reset;
		@(posedge i_core_clk);
	endtask
	task automatic t_reset();
		rd(8'hf2, 8'h17);
		rd(8'hf6, 8'h00);
		rd(8'hf4, 8'h7f);
		bus(1, 0, 8'hf4, 8'h05);
		rd(8'hf4, 8'h05);
	endtask
	task automatic t_basic();
		int n, p;
		logic rs;
		for (int s = 0; s < 4; s++) begin
			p = 2048 << s;
			bus(1, 0, 8'hf1, 8'hff);
			bus(1, 0, 8'hf2, 8'h18 | s[7:0]);
			bus(0, 0, 8'h00, 8'h00);
			rd(8'hf1, 8'h00);
			rd(8'hf2, 8'h10 | s[7:0]);
			ev(0, n, rs);
			cmp(8'(n > p - (8 << s) - 20 && n < p + 20), 8'h01);
		end
		rd(8'hf8, 8'h01);
		rd(8'hf8, 8'h00);
	endtask
	task automatic t_wdog();
		logic [23:0] cs[4] = '{24'h100001, 24'h10a500, 24'h10a401, 24'h000000};
		int n;
		logic rs;
		bus(1, 0, 8'hf9, 8'h02);
		for (int i = 0; i < 4; i++) begin
			bus(1, 0, 8'hf2, cs[i][23:16]);
			bus(1, 0, 8'hf6, cs[i][15:8]);
			bus(1, 0, 8'hf4, 8'h81);
			ev(1, n, rs);
			cmp(8'(n < 4200), 8'h01);
			cmp({7'h00, rs}, {7'h00, cs[i][0]});
			#1 cmp({7'h00, o_irq}, 8'h01);
			// a match is taken on an overflow step, so the overflow bit is set beside it
			rd(8'hf8, 8'h03);
			#1 cmp({7'h00, o_irq}, 8'h00);
		end
		ev(1, n, rs);
		cmp({7'h00, rs}, 8'h00);
		cmp(8'(n < 20000), 8'h01);
	endtask
	task automatic conclude();
		$display("errors=%0d checks=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#5000000;
		error_cnt++;
		conclude();
	end
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_reset <= 0;
		@(posedge i_core_clk);
		t_reset();
		t_basic();
		t_wdog();
		conclude();
	end
endmodule
